/* bus_mem_cfg.svh */
/*
  Backplane slave constants: timing, codes, sizes, bits, register map.
  Assumes a 200 MHz CLOCK; included by bare name.
*/
`ifndef BUS_MEM_CFG_SVH
`define BUS_MEM_CFG_SVH

// clock and acknowledge timing
`define CLK_PERIOD_NS 5
`define EARLY_ACK_NS 270
`define NORMAL_ACK_NS 350
// sync, decode and reply flop cycles beside the wait
`define ACK_OVERHEAD_CYC 5
// longest time rounds down, least time rounds up
`define EARLY_WAIT_CYC 7'((`EARLY_ACK_NS / `CLK_PERIOD_NS) - `ACK_OVERHEAD_CYC)
`define NORMAL_WAIT_CYC 7'(((`NORMAL_ACK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) - `ACK_OVERHEAD_CYC)
`define WAIT_ZERO 7'h00
`define WAIT_ONE 7'h01

// modifier codes
`define AM_IO 8'h15
`define AM_STD_A 8'h01
`define AM_STD_B 8'h02
`define AM_STD_C 8'h05
`define AM_STD_D 8'h06
`define AM_EXT_A 8'hF1
`define AM_EXT_B 8'hF2
`define AM_EXT_C 8'hF5
`define AM_EXT_D 8'hF6
`define AM_BOTH 8'hFF

// short i/o page and window sizes in 64K granules
`define IO_PAGE 8'hFF
`define UPPER_ZERO 8'h00
`define SIZE_1MB_GRAN 9'h010
`define SIZE_4MB_GRAN 9'h040
`define PAGE_TOP_GRAN 9'h100

// control/status word
`define CSR_PERR_BIT 15
`define CSR_REPORT_BIT 0
`define CSR_RSVD 14'h0000

// local register map (byte offsets, low address byte)
`define REG_IRQ_STATUS 8'h00
`define REG_IRQ_CLEAR 8'h04
`define REG_IRQ_ENABLE 8'h08
`define REG_CSR_VIEW 8'h0C
`define REG_CTRL 8'h10
`define REG_STRAP_VIEW 8'h14

// interrupt event bits
`define IRQ_PARITY 0
`define IRQ_BERR 1
`define IRQ_CSR_WR 2
`define IRQ_W 3
`define IRQ_NONE 3'h0

// control register
`define CTRL_DECODE_EN 0
`define CTRL_RESET 1'h1

`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'h0
`define WORD_ZERO 32'h0000_0000

`endif

/* bus_mem_pkg.sv */
/*
  Shared types of the backplane slave.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package bus_mem_pkg;

  // one request, strobes active high
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] am;
    logic write;
    logic lword;
    logic ds1;
    logic ds0;
    logic [15:0] data;
  } bus_req_t;

  // straps and switches, 1 = fitted or closed
  typedef struct packed {
    logic [15:1] csr_addr;
    logic ram_type;
    logic early_ack;
    logic mem_size;
    logic bus_err_en;
    logic report_pol;
    logic ext_addr;
    logic mod_mode;
    logic [7:0] start_upper;
    logic [7:0] start_lower;
  } straps_t;

  typedef struct packed {
    logic mem_hit;
    logic csr_hit;
  } decode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DECODE,
    ST_WAIT,
    ST_REPLY,
    ST_RELEASE
  } cycle_state_t;

endpackage

`default_nettype wire

/* bus_sync.sv */
/*
  Two-flop level synchroniser.
  Assumes inputs quasi-static across the sampling window.
*/
`timescale 1ns/10ps
`default_nettype none

module bus_sync #(
  parameter int WIDTH = 1
) (
  input wire logic CLOCK, // system clock
  input wire logic SYS_RST, // synchronous reset, high
  input wire logic [WIDTH-1:0] d, // asynchronous level
  output logic [WIDTH-1:0] q // synchronised level
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

`default_nettype wire

/* mem_window_decode.sv */
/*
  Window and control word decode, combinational.
  Assumes synchronised request and straps.
*/
`timescale 1ns/10ps
`default_nettype none
`include "bus_mem_cfg.svh"

module mem_window_decode (
  input wire bus_mem_pkg::bus_req_t req, // latched request
  input wire bus_mem_pkg::straps_t straps, // board configuration
  output bus_mem_pkg::decode_t hit // memory or word hit
);
  import bus_mem_pkg::*;

  logic [15:0] gran;
  logic upper_ok;
  logic am_mem_ok;
  logic [8:0] size_gran;
  logic [8:0] sum_gran;
  logic [8:0] end_gran;
  logic in_win;

  // RL4: 24-bit standard view
  assign gran = straps.mod_mode ? req.addr[31:16] : {`UPPER_ZERO, req.addr[23:16]};

  // RL6: upper switches ignored
  assign upper_ok = !straps.ext_addr || (gran[15:8] == straps.start_upper);

  // RL9: strap sets size
  assign size_gran = straps.mem_size ? `SIZE_4MB_GRAN : `SIZE_1MB_GRAN;

  // RL7: end is start plus size
  assign sum_gran = {1'b0, straps.start_lower} + size_gran;

  // RL8: clamp at page boundary
  assign end_gran = (sum_gran > `PAGE_TOP_GRAN) ? `PAGE_TOP_GRAN : sum_gran;

  // RL5: 64K granule compare; RL19: closed switch means one
  assign in_win = (gran[7:0] >= straps.start_lower) && ({1'b0, gran[7:0]} < end_gran);

  // RL4: modifier acceptance per mode
  always_comb begin
    if (straps.mod_mode) begin
      am_mem_ok = (req.am == `AM_EXT_A) || (req.am == `AM_EXT_B) || (req.am == `AM_EXT_C) ||
                  (req.am == `AM_EXT_D) || (req.am == `AM_BOTH);
    end else begin
      am_mem_ok = (req.am == `AM_STD_A) || (req.am == `AM_STD_B) || (req.am == `AM_STD_C) ||
                  (req.am == `AM_STD_D) || (req.am == `AM_BOTH);
    end
  end

  assign hit.mem_hit = am_mem_ok && upper_ok && in_win;

  // RL1: one word in FF page; RL2: strap position; RL3: code 15 only
  assign hit.csr_hit = (req.am == `AM_IO) && (req.addr[23:16] == `IO_PAGE) &&
                       (req.addr[15:1] == straps.csr_addr);

endmodule

`default_nettype wire

/* bus_mem_slave.sv */
/*
  Backplane memory slave: cycle control,
  answer timing, control word,
  ahb-lite window, level interrupt.
  Assumes async backplane pins,
  strobes held until answered; array
  flags parity on PARITY_ERR.
*/
`timescale 1ns/10ps
`default_nettype none
`include "bus_mem_cfg.svh"

// Contract
// RL1: control word is one 16-bit word inside the FF0000-FFFFFF i/o page
// RL2: fifteen straps set word address bits 1..15; none fitted gives FF0000
// RL3: i/o access to the word is accepted only with modifier code 15
// RL4: mode strap picks 24-bit standard codes or 32-bit extended codes
// RL5: window start is any 64K boundary set by switches on bits 16..31
// RL6: extended-address strap off ignores the upper eight start switches
// RL7: window ends at start plus installed size
// RL8: start within 1 MB of page top ends window at page boundary
// RL9: size strap picks one megabyte or four megabytes
// RL10: early strap gives acknowledge within 270 ns of data strobe
// RL11: early mode does not flag read parity errors
// RL12: bus error never driven while bus-error strap is removed
// RL13: reported read parity error sets word bit 15
// RL14: polarity strap absent, writing 1 to bit 0 enables reporting
// RL15: polarity strap fitted, bit 0 is 0 and enables; 1 disables
// RL16: acknowledge after write data taken or read data driven
// RL17: master picks size by strobes, A1, longword; write line high for read
// RL18: reported parity error in normal timing gives bus error instead
// RL19: each closed switch requires its address bit one; all must match (lower switches only set the start of a range compare)
module bus_mem_slave (
  input wire logic CLOCK, // system clock, 200 MHz
  input wire logic SYS_RST, // synchronous reset, active high
  input wire logic HSEL, // ahb slave select
  input wire logic [31:0] HADDR, // ahb address
  input wire logic [1:0] HTRANS, // ahb transfer type
  input wire logic HWRITE, // ahb write
  input wire logic [2:0] HSIZE, // ahb size, word only
  input wire logic [31:0] HWDATA, // ahb write data
  input wire logic HREADY, // ahb ready in
  output logic [31:0] HRDATA, // ahb read data
  output logic HREADYOUT, // ahb ready out
  output logic HRESP, // ahb response
  output logic IRQ, // level interrupt
  input wire logic [31:0] BUS_ADDR, // backplane address
  input wire logic [7:0] BUS_AM, // backplane modifier code
  input wire logic BUS_DS0_N, // low byte strobe
  input wire logic BUS_DS1_N, // high byte strobe
  input wire logic BUS_WRITE_N, // low for write
  input wire logic BUS_LWORD_N, // low for longword
  input wire logic [15:0] BUS_DATA_I, // data lines in
  output logic [15:0] BUS_DATA_O, // data lines out
  output logic BUS_DATA_OE_N, // data drive enable, low drives
  output logic BUS_DTACK_N_O, // acknowledge level, always low
  output logic BUS_DTACK_OE_N, // acknowledge drive, low drives
  output logic BUS_BERR_N_O, // bus error level, always low
  output logic BUS_BERR_OE_N, // bus error drive, low drives
  input wire logic PARITY_ERR, // read parity fault from array
  output logic BOARD_SELECT, // memory cycle select to array
  input wire logic [6:0] CSR_ADDR_LOW_STRAPS, // word address bits 1..7
  input wire logic [7:0] CSR_ADDR_HIGH_STRAPS, // word address bits 8..15
  input wire logic RAM_TYPE_STRAP, // 1 = 256K parts fitted
  input wire logic EARLY_ACK_STRAP, // 1 = early acknowledge
  input wire logic MEM_SIZE_STRAP, // 1 = four megabytes
  input wire logic BUS_ERR_ENABLE_STRAP, // 1 = bus error allowed
  input wire logic PARITY_REPORT_POLARITY_STRAP, // 1 = reporting on at reset
  input wire logic EXTENDED_ADDR_STRAP, // 1 = upper switches used
  input wire logic MODIFIER_MODE_STRAP, // 1 = extended codes
  input wire logic [7:0] START_ADDR_SWITCH_UPPER, // start bits 24..31
  input wire logic [7:0] START_ADDR_SWITCH_LOWER // start bits 16..23
);
  import bus_mem_pkg::*;

  bus_req_t raw_req;
  bus_req_t s_req;
  bus_req_t cur;
  straps_t raw_straps;
  straps_t straps;
  decode_t hit;
  cycle_state_t state;
  logic s_perr;
  logic ds_act;
  logic cur_mem;
  logic cur_csr;
  logic [6:0] wait_cnt;
  logic report_bit;
  logic perr_flag;
  logic report_en;
  logic perr_now;
  logic berr_now;
  logic reply_go;
  logic csr_wr_ev;
  logic dtack_drive;
  logic berr_drive;
  logic data_drive;
  logic [`IRQ_W-1:0] irq_status;
  logic [`IRQ_W-1:0] irq_enable;
  logic [`IRQ_W-1:0] irq_event;
  logic [`IRQ_W-1:0] irq_clear;
  logic decode_en;
  logic ahb_wr;
  logic [7:0] ahb_addr;
  logic ahb_take;
  logic [31:0] next_hrdata;

  // RL17: master sets size and direction, strobes normalised to active high
  assign raw_req = '{addr: BUS_ADDR, am: BUS_AM, write: ~BUS_WRITE_N, lword: ~BUS_LWORD_N,
                     ds1: ~BUS_DS1_N, ds0: ~BUS_DS0_N, data: BUS_DATA_I};
  assign raw_straps = '{csr_addr: {CSR_ADDR_HIGH_STRAPS, CSR_ADDR_LOW_STRAPS},
                        ram_type: RAM_TYPE_STRAP, early_ack: EARLY_ACK_STRAP,
                        mem_size: MEM_SIZE_STRAP, bus_err_en: BUS_ERR_ENABLE_STRAP,
                        report_pol: PARITY_REPORT_POLARITY_STRAP, ext_addr: EXTENDED_ADDR_STRAP,
                        mod_mode: MODIFIER_MODE_STRAP, start_upper: START_ADDR_SWITCH_UPPER,
                        start_lower: START_ADDR_SWITCH_LOWER};

  // backplane pins cross two flops first
  bus_sync #(.WIDTH($bits(bus_req_t))) u_req_sync (
    .CLOCK(CLOCK),
    .SYS_RST(SYS_RST),
    .d(raw_req),
    .q(s_req)
  );

  bus_sync #(.WIDTH($bits(straps_t))) u_strap_sync (
    .CLOCK(CLOCK),
    .SYS_RST(SYS_RST),
    .d(raw_straps),
    .q(straps)
  );

  bus_sync #(.WIDTH(1)) u_perr_sync (
    .CLOCK(CLOCK),
    .SYS_RST(SYS_RST),
    .d(PARITY_ERR),
    .q(s_perr)
  );

  mem_window_decode u_decode (
    .req(cur),
    .straps(straps),
    .hit(hit)
  );

  assign ds_act = s_req.ds0 | s_req.ds1;

  // latch request at strobe start; address settles first
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      cur <= '0;
    end else if (state == ST_IDLE && ds_act) begin
      cur <= s_req;
    end
  end

  // RL14: strap absent, bit 0 set enables; RL15: strap fitted, bit 0 set disables
  assign report_en = straps.report_pol ? ~report_bit : report_bit;

  assign reply_go = (state == ST_WAIT) && (wait_cnt == `WAIT_ZERO);

  // RL13: reported read parity; RL11: never flagged in early mode
  assign perr_now = reply_go && cur_mem && !cur.write && s_perr && report_en && !straps.early_ack;

  // RL18: bus error replaces acknowledge; RL12: only with strap fitted
  assign berr_now = perr_now && straps.bus_err_en;

  assign csr_wr_ev = (state == ST_DECODE) && decode_en && hit.csr_hit && cur.write;

  // sequencer: decode, wait, reply until strobes release
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (ds_act) begin
            state <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          if (decode_en && (hit.mem_hit || hit.csr_hit)) begin
            state <= ST_WAIT;
          end else begin
            state <= ST_RELEASE;
          end
        end
        ST_WAIT: begin
          if (wait_cnt == `WAIT_ZERO) begin
            state <= ST_REPLY;
          end
        end
        ST_REPLY: begin
          if (!ds_act) begin
            state <= ST_IDLE;
          end
        end
        ST_RELEASE: begin
          if (!ds_act) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // target of current cycle, kept to reply end
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      cur_mem <= 1'b0;
      cur_csr <= 1'b0;
    end else if (state == ST_DECODE) begin
      cur_mem <= decode_en && hit.mem_hit;
      cur_csr <= decode_en && hit.csr_hit && !hit.mem_hit;
    end else if (state == ST_IDLE) begin
      cur_mem <= 1'b0;
      cur_csr <= 1'b0;
    end
  end

  // RL10: early count meets 270 ns; normal count leaves room for read access
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      wait_cnt <= `WAIT_ZERO;
    end else if (state == ST_DECODE) begin
      wait_cnt <= straps.early_ack ? `EARLY_WAIT_CYC : `NORMAL_WAIT_CYC;
    end else if (state == ST_WAIT && wait_cnt != `WAIT_ZERO) begin
      wait_cnt <= wait_cnt - `WAIT_ONE;
    end
  end

  // array select from decode until strobes go
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      BOARD_SELECT <= 1'b0;
    end else if (state == ST_DECODE) begin
      BOARD_SELECT <= decode_en && hit.mem_hit;
    end else if (state == ST_IDLE || state == ST_RELEASE) begin
      BOARD_SELECT <= 1'b0;
    end
  end

  // RL16: acknowledge once data is taken or driven
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      dtack_drive <= 1'b0;
      berr_drive <= 1'b0;
    end else if (reply_go) begin
      dtack_drive <= !berr_now;
      berr_drive <= berr_now;
    end else if (state == ST_REPLY && !ds_act) begin
      dtack_drive <= 1'b0;
      berr_drive <= 1'b0;
    end
  end

  // word read data loaded at decode
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      BUS_DATA_O <= 16'h0000;
      data_drive <= 1'b0;
    end else if (state == ST_DECODE) begin
      BUS_DATA_O <= {perr_flag, `CSR_RSVD, report_bit};
      data_drive <= decode_en && hit.csr_hit && !hit.mem_hit && !cur.write;
    end else if (state == ST_IDLE || state == ST_RELEASE) begin
      data_drive <= 1'b0;
    end
  end

  // open-drain style pins: level fixed low, enable active low
  assign BUS_DTACK_N_O = 1'b0;
  assign BUS_BERR_N_O = 1'b0;
  assign BUS_DTACK_OE_N = ~dtack_drive;
  // RL12: nothing else reaches the bus error pin
  assign BUS_BERR_OE_N = ~(berr_drive && straps.bus_err_en);
  assign BUS_DATA_OE_N = ~data_drive;

  // RL14: bit 0 written from the low byte; reset value 0
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      report_bit <= 1'b0;
    end else if (csr_wr_ev && cur.ds0) begin
      report_bit <= cur.data[`CSR_REPORT_BIT];
    end
  end

  // RL13: sticky error bit, a 1 in bit 15 clears it; a new error wins
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      perr_flag <= 1'b0;
    end else if (perr_now) begin
      perr_flag <= 1'b1;
    end else if (csr_wr_ev && cur.ds1 && cur.data[`CSR_PERR_BIT]) begin
      perr_flag <= 1'b0;
    end
  end

  // local interrupt events, each one clock wide
  always_comb begin
    irq_event = `IRQ_NONE;
    irq_event[`IRQ_PARITY] = perr_now;
    irq_event[`IRQ_BERR] = berr_now && straps.bus_err_en;
    irq_event[`IRQ_CSR_WR] = csr_wr_ev;
  end

  // ahb-lite address phase capture; slave never waits
  assign ahb_take = HSEL && HTRANS[`HTRANS_NONSEQ_BIT] && HREADY;
  assign HREADYOUT = 1'b1;
  assign HRESP = `HRESP_OKAY;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ahb_wr <= 1'b0;
      ahb_addr <= 8'h00;
    end else begin
      ahb_wr <= ahb_take && HWRITE;
      ahb_addr <= HADDR[7:0];
    end
  end

  assign irq_clear = (ahb_wr && ahb_addr == `REG_IRQ_CLEAR) ? HWDATA[`IRQ_W-1:0] : `IRQ_NONE;

  // sticky status: set beats clear in the same cycle
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      irq_status <= `IRQ_NONE;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end

  // software-owned enable and decode control
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      irq_enable <= `IRQ_NONE;
      decode_en <= `CTRL_RESET;
    end else if (ahb_wr && ahb_addr == `REG_IRQ_ENABLE) begin
      irq_enable <= HWDATA[`IRQ_W-1:0];
    end else if (ahb_wr && ahb_addr == `REG_CTRL) begin
      decode_en <= HWDATA[`CTRL_DECODE_EN];
    end
  end

  // read mux in address phase; unmapped and write-only read 0
  always_comb begin
    next_hrdata = `WORD_ZERO;
    case (HADDR[7:0])
      `REG_IRQ_STATUS: next_hrdata = {29'h0000_0000, irq_status};
      `REG_IRQ_ENABLE: next_hrdata = {29'h0000_0000, irq_enable};
      `REG_CSR_VIEW: next_hrdata = {16'h0000, perr_flag, `CSR_RSVD, report_bit};
      `REG_CTRL: next_hrdata = {31'h0000_0000, decode_en};
      `REG_STRAP_VIEW: next_hrdata = {9'h000, straps.ram_type, straps.early_ack, straps.mem_size,
                                      straps.bus_err_en, straps.report_pol, straps.ext_addr,
                                      straps.mod_mode, straps.start_upper, straps.start_lower};
      default: next_hrdata = `WORD_ZERO;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      HRDATA <= `WORD_ZERO;
    end else if (ahb_take && !HWRITE) begin
      HRDATA <= next_hrdata;
    end
  end

  // level interrupt from enabled sticky bits
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status & irq_enable);
    end
  end

endmodule

`default_nettype wire

/* bus_mem_slave_sva.sv */
/*
  Checker: answer timing, bus error gating, drive release.
  Sees top ports only; bind follows.
*/
`timescale 1ns/10ps
`default_nettype none
module bus_mem_slave_sva (
  input wire logic CLOCK, // clock
  input wire logic SYS_RST, // reset
  input wire logic HREADYOUT, // ahb ready
  input wire logic HRESP, // ahb response
  input wire logic BUS_DS0_N, // low strobe
  input wire logic BUS_DS1_N, // high strobe
  input wire logic BUS_WRITE_N, // write line
  input wire logic BUS_DATA_OE_N, // data drive
  input wire logic BUS_DTACK_OE_N, // acknowledge drive
  input wire logic BUS_BERR_OE_N, // bus error drive
  input wire logic BOARD_SELECT, // window hit
  input wire logic EARLY_ACK_STRAP, // early strap
  input wire logic BUS_ERR_ENABLE_STRAP // bus error strap
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);
  logic [7:0] held;
  wire logic idle;
  // no cycle while both strobes are high
  assign idle = BUS_DS0_N & BUS_DS1_N;
  // cycles since strobe fell; misses end before wrap
  always_ff @(posedge CLOCK) held <= (SYS_RST || idle) ? 8'h00 : held + 8'h01;
  a_early_ack_bound: assert property ($fell(BUS_DTACK_OE_N) && EARLY_ACK_STRAP |-> held <= 8'h39)
    else $error("early ack late");
  a_normal_ack_time: assert property ($fell(BUS_DTACK_OE_N) && !EARLY_ACK_STRAP |-> held >= 8'h44)
    else $error("normal ack early");
  a_berr_normal_only: assert property ($fell(BUS_BERR_OE_N) |-> !EARLY_ACK_STRAP && held >= 8'h44)
    else $error("berr not normal");
  a_berr_gated: assert property ((!BUS_ERR_ENABLE_STRAP) [*3] |-> BUS_BERR_OE_N)
    else $error("berr strap off");
  a_early_no_berr: assert property (EARLY_ACK_STRAP [*3] |-> BUS_BERR_OE_N)
    else $error("bus error in early mode");
  a_one_answer: assert property (!(!BUS_DTACK_OE_N && !BUS_BERR_OE_N))
    else $error("ack with berr");
  a_ack_hold: assert property (!BUS_DTACK_OE_N && !idle |=> !BUS_DTACK_OE_N)
    else $error("ack dropped");
  a_idle_release: assert property (idle [*6] |-> BUS_DTACK_OE_N && BUS_BERR_OE_N && BUS_DATA_OE_N && !BOARD_SELECT)
    else $error("drive kept");
  a_data_on_read: assert property (!BUS_DATA_OE_N |-> BUS_WRITE_N)
    else $error("data on write");
  a_ahb_okay: assert property (HREADYOUT && !HRESP)
    else $error("ahb not okay");
  c_ack: cover property ($fell(BUS_DTACK_OE_N) && EARLY_ACK_STRAP);
  c_berr: cover property ($fell(BUS_BERR_OE_N));
  c_read: cover property (!BUS_DATA_OE_N && !BUS_DTACK_OE_N);
endmodule
bind bus_mem_slave bus_mem_slave_sva chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .BUS_DS0_N(BUS_DS0_N), .BUS_DS1_N(BUS_DS1_N), .BUS_WRITE_N(BUS_WRITE_N), .BUS_DATA_OE_N(BUS_DATA_OE_N),
  .BUS_DTACK_OE_N(BUS_DTACK_OE_N), .BUS_BERR_OE_N(BUS_BERR_OE_N), .BOARD_SELECT(BOARD_SELECT),
  .EARLY_ACK_STRAP(EARLY_ACK_STRAP), .BUS_ERR_ENABLE_STRAP(BUS_ERR_ENABLE_STRAP));
`default_nettype wire

/* bp_master_model.sv */
/*
  Backplane master: one word transfer per run call.
  Assumes low-active slave enables on CLOCK.
*/
`timescale 1ns/10ps
`default_nettype none
module bp_master_model (
  input wire logic CLOCK, // clock
  output logic [31:0] addr, // address
  output logic [7:0] am, // modifier code
  output logic ds_n, // both strobes
  output logic write_n, // write line
  output wire logic [15:0] data, // data out
  input wire logic [15:0] rdata, // slave data
  input wire logic dtack_oe_n, // acknowledge
  input wire logic berr_oe_n // bus error
);
  logic [15:0] wd;
  logic [15:0] pat;
  initial begin
    addr = 32'h0000_0000;
    am = 8'h00;
    ds_n = 1'b1;
    write_n = 1'b1;
    wd = 16'h0000;
    pat = 16'hA5C3;
  end
  // released lines keep moving: stale data cannot pass
  always @(posedge CLOCK) pat <= {pat[14:0], ~pat[15]};
  assign data = (!write_n && !ds_n) ? wd : pat;
  // word transfer, read keeps write high
  task automatic run(input logic [31:0] a, input logic [7:0] m, input logic w, input logic [15:0] d,
                     output logic [1:0] res, output logic [15:0] rd);
    int n;
    res = 2'h0;
    n = 0;
    @(posedge CLOCK);
    addr <= a;
    am <= m;
    write_n <= !w;
    wd <= d;
    ds_n <= 1'b0;
    // misses never answer: bounded wait
    while (res == 2'h0 && n < 120) begin
      @(posedge CLOCK);
      n++;
      res = (dtack_oe_n === 1'b0) ? 2'h1 : (berr_oe_n === 1'b0) ? 2'h2 : 2'h0;
    end
    rd = rdata;
    ds_n <= 1'b1;
    repeat (6) @(posedge CLOCK);
  endtask
endmodule
`default_nettype wire

/* bus_memory_slave_decode_config_bench.sv */
/*
  Bench: ahb registers, irq, control word, random window trials.
  Needs the master model and bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
module bus_memory_slave_decode_config_bench;
  import bus_mem_pkg::*;
  logic CLOCK = 1'b0;
  logic SYS_RST = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, perr = 1'b0, pe, w, hit, on, bad, csr0, rep, ber;
  logic [1:0] htrans = 2'h0, res;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, ca, a, b_addr;
  logic hready, hresp, irq, ds_n, wr_n, doe, dtk, berr;
  logic [15:0] mdata, dout, rd;
  logic [7:0] b_am, m;
  straps_t st, nx;
  int fails = 0, checks_done = 0;
  logic [7:0] codes [11] = '{8'h01, 8'h02, 8'h05, 8'h06, 8'hFF, 8'hF1, 8'hF2, 8'hF5, 8'hF6, 8'h15, 8'h29};
  wire logic [15:0] bus_in = (doe === 1'b0) ? dout : mdata;
  always #2.5 CLOCK = ~CLOCK;
  bus_mem_slave dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
    .HRESP(hresp), .IRQ(irq), .BUS_ADDR(b_addr), .BUS_AM(b_am), .BUS_DS0_N(ds_n), .BUS_DS1_N(ds_n),
    .BUS_WRITE_N(wr_n), .BUS_LWORD_N(1'b1), .BUS_DATA_I(bus_in), .BUS_DATA_O(dout), .BUS_DATA_OE_N(doe),
    .BUS_DTACK_N_O(), .BUS_DTACK_OE_N(dtk), .BUS_BERR_N_O(), .BUS_BERR_OE_N(berr), .PARITY_ERR(perr),
    .BOARD_SELECT(), .CSR_ADDR_LOW_STRAPS(st.csr_addr[7:1]), .CSR_ADDR_HIGH_STRAPS(st.csr_addr[15:8]),
    .RAM_TYPE_STRAP(st.ram_type), .EARLY_ACK_STRAP(st.early_ack), .MEM_SIZE_STRAP(st.mem_size),
    .BUS_ERR_ENABLE_STRAP(st.bus_err_en), .PARITY_REPORT_POLARITY_STRAP(st.report_pol),
    .EXTENDED_ADDR_STRAP(st.ext_addr), .MODIFIER_MODE_STRAP(st.mod_mode),
    .START_ADDR_SWITCH_UPPER(st.start_upper), .START_ADDR_SWITCH_LOWER(st.start_lower));
  bp_master_model bpm (.CLOCK(CLOCK), .addr(b_addr), .am(b_am), .ds_n(ds_n), .write_n(wr_n), .data(mdata),
    .rdata(dout), .dtack_oe_n(dtk), .berr_oe_n(berr));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
    @(posedge CLOCK);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, ad};
    do @(posedge CLOCK); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge CLOCK); while (hready !== 1'b1);
    q = hrdata;
  endtask
  function automatic logic exp_hit(input logic [31:0] ad, input logic [7:0] c);
    logic [8:0] s, e;
    logic ok;
    ok = st.mod_mode ? c inside {8'hF1, 8'hF2, 8'hF5, 8'hF6, 8'hFF}
                     : c inside {8'h01, 8'h02, 8'h05, 8'h06, 8'hFF};
    s = {1'b0, st.start_lower};
    e = s + (st.mem_size ? 9'h040 : 9'h010);
    e = (e > 9'h100) ? 9'h100 : e;
    return ok && (!st.ext_addr || ad[31:24] == st.start_upper) && {1'b0, ad[23:16]} >= s && {1'b0, ad[23:16]} < e;
  endfunction
  task automatic tally_and_finish;
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, well past run length
  initial begin
    repeat (60000) @(posedge CLOCK);
    fails++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(93));
    st = 38'({$urandom, $urandom});
    st.report_pol = 1'b1;
    st.ext_addr = st.ext_addr & st.mod_mode;
    {csr0, rep, ber} = 3'h0;
    repeat (6) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    // fitted polarity reads bit 0 low
    ahb(1'b0, 8'h0C, 32'h0, r);
    check(r, 32'h0);
    ahb(1'b0, 8'h14, 32'h0, r);
    check(r, {9'h0, st[22:0]});
    ahb(1'b0, 8'h18, 32'h0, r);
    check(r, 32'h0);
    ahb(1'b1, 8'h08, 32'h4, r);
    ca = {8'h5A, 8'hFF, st.csr_addr, 1'b0};
    // wrong word, page or code: ignored
    for (int i = 0; i < 3; i++) begin
      bpm.run(i == 0 ? ca ^ 32'h2 : i == 1 ? ca ^ 32'h10000 : ca, i == 2 ? 8'h29 : 8'h15, 1'b1, 16'h1, res, rd);
      check(res, 2'h0);
    end
    check(irq, 1'b0);
    bpm.run(ca, 8'h15, 1'b1, 16'h0001, res, rd);
    check(res, 2'h1);
    csr0 = 1'b1;
    check(irq, 1'b1);
    bpm.run(ca, 8'h15, 1'b0, 16'h0, res, rd);
    check({res, rd}, {2'h1, 16'h0001});
    ahb(1'b1, 8'h08, 32'h0, r);
    repeat (2) @(posedge CLOCK);
    check(irq, 1'b0);
    ahb(1'b1, 8'h04, 32'h4, r);
    ahb(1'b1, 8'h08, 32'h4, r);
    ahb(1'b0, 8'h00, 32'h0, r);
    check({r, irq}, 33'h0);
    for (int t = 0; t < 40; t++) begin
      nx = 38'({$urandom, $urandom});
      nx.csr_addr = st.csr_addr;
      nx.ext_addr = nx.ext_addr & nx.mod_mode;
      nx.ram_type = nx.mem_size;
      pe = !nx.early_ack && $urandom_range(1);
      @(posedge CLOCK);
      st <= nx;
      perr <= pe;
      repeat (4) @(posedge CLOCK);
      a = {$urandom_range(1) ? st.start_upper : 8'($urandom), 8'(st.start_lower + $urandom_range(72) - 4),
           16'($urandom) & 16'hFFFE};
      m = codes[$urandom_range(10)];
      w = $urandom_range(1);
      hit = exp_hit(a, m);
      on = st.report_pol ? !csr0 : csr0;
      bad = hit && !w && pe && on;
      rep = rep | bad;
      ber = ber | (bad && st.bus_err_en);
      bpm.run(a, m, w, 16'($urandom), res, rd);
      check(res, !hit ? 2'h0 : (bad && st.bus_err_en) ? 2'h2 : 2'h1);
    end
    perr <= 1'b0;
    ahb(1'b0, 8'h0C, 32'h0, r);
    check(r, {16'h0, rep, 14'h0, csr0});
    ahb(1'b0, 8'h00, 32'h0, r);
    check(r, {30'h0, ber, rep});
    a = {st.start_upper, st.start_lower, 16'h0};
    m = st.mod_mode ? 8'hF1 : 8'h01;
    ahb(1'b1, 8'h10, 32'h0, r);
    bpm.run(a, m, 1'b1, 16'h0, res, rd);
    check(res, 2'h0);
    ahb(1'b1, 8'h10, 32'h1, r);
    bpm.run(a, m, 1'b1, 16'h0, res, rd);
    check(res, 2'h1);
    tally_and_finish;
  end
endmodule
`default_nettype wire
